// ### rtl/sld_blink.sv
// Free-running blink phase generator for the status LEDs.
// Assumes a synchronous active-low reset.
`timescale 1ns/10ps
module sld_blink #(
    parameter int HALF_CYC = sld_pkg::BLINK_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    output logic phase
);
    localparam int W = $clog2(HALF_CYC + 1);
    logic [W-1:0] cnt_q;
    logic phase_q;
    wire logic wrap = (cnt_q == W'(HALF_CYC - 1));

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q <= '0;
            phase_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? '0 : cnt_q + W'(1);
            phase_q <= wrap ? ~phase_q : phase_q;
        end
    end

    assign phase = phase_q;
endmodule // sld_blink

// ### rtl/sld_pkg.sv
// Package for the status LED and display driver: register map, fields, timing.
// Assumes a 10 MHz system clock and an Avalon-MM slave with 32-bit data.
package sld_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_INT_STAT = 4'h4;
    localparam logic [3:0] OFS_INT_MASK = 4'h8;
    localparam logic [3:0] OFS_CTRL = 4'hc;

    // ==========================================================
    // Interrupt bit positions
    localparam int IRQ_BLANK = 0;
    localparam int IRQ_WAKE = 1;
    localparam int IRQ_PAGE = 2;
    localparam int IRQ_FAULT = 3;
    localparam int IRQ_W = 4;

    // ==========================================================
    // Control field positions and reset value
    localparam int CTRL_PAGES_LSB = 0;
    localparam int CTRL_PAGES_W = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int BLANK_S = 60;
    localparam longint BLANK_CYC = longint'(BLANK_S) * longint'(CLK_HZ);
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = (BLINK_MS * (CLK_HZ / 1000));

    // ==========================================================
    // Operating state inputs
    typedef struct packed {
        logic startup;
        logic out_on;
        logic off_field;
        logic off_fault;
        logic reset_cfg;
        logic interlock;
        logic auto_cfg;
        logic restart_cnt;
        logic warn_int;
        logic eth_link;
        logic eth_traffic;
        logic notify;
    } sld_state_t;

    // LED drive
    typedef struct packed {
        logic on_green;
        logic off_red;
        logic rw_yellow;
        logic net_green;
        logic net_yellow;
    } sld_led_t;

    typedef enum logic [1:0] {
        SLD_DISP_BOOT = 2'b00,
        SLD_DISP_ON = 2'b01,
        SLD_DISP_OFF = 2'b10
    } sld_disp_t;

endpackage

// ### rtl/sld_top.sv
// Status LED and display driver: maps operating state to LEDs and the display.
// Assumes state inputs synchronous to clk and an Avalon-MM master on the bus.
// Contract
// [RULE_01] Green ON LED lit while any safety output is ON.
// [RULE_02] Red OFF LED steady while an output is OFF from a field interruption.
// [RULE_03] Red OFF LED blinks while an output is OFF from a fault.
// [RULE_04] With reset configured, yellow LED blinks while restart interlock is engaged.
// [RULE_05] With automatic restart, yellow LED steady while restart delay counts.
// [RULE_06] Yellow LED lit while any warning field is interrupted.
// [RULE_07] Network LED green while an Ethernet link exists.
// [RULE_08] Network LED blinks yellow during Ethernet data traffic.
// [RULE_09] During start-up tests, OFF LED steady and ON LED dark.
// [RULE_10] After start-up, LEDs and display follow the current operating state.
// [RULE_11] Display blanks after 60 s quiet; any interruption or notice restarts timer.
// [RULE_12] Indicator logic is diagnostic only and never feeds the safety outputs.
// [RULE_13] While blanked, a short button press turns the display back on.
// [RULE_14] A short press advances to the next detail page when several exist.
// [RULE_15] Blinking interlock indication overrides steady yellow indications.
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module sld_top #(
    parameter longint BLANK_CYC = sld_pkg::BLANK_CYC,
    parameter int BLINK_CYC = sld_pkg::BLINK_CYC,
    parameter int PAGE_W = sld_pkg::CTRL_PAGES_W
) (
    input wire logic clk,
    input wire logic rstn,
    input sld_pkg::sld_state_t state,
    input wire logic button,
    output sld_pkg::sld_led_t led,
    output logic disp_on,
    output logic [PAGE_W-1:0] disp_page,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    localparam int TW = 40;

    // ==========================================================
    // Blink phase
    logic phase;
    sld_blink #(.HALF_CYC(BLINK_CYC)) u_blink (
        .clk(clk),
        .rstn(rstn),
        .phase(phase)
    );

    // ==========================================================
    // LED mapping; outputs only, nothing returns to safety logic
    wire logic boot = state.startup;
    wire logic yel_blink = state.reset_cfg & state.interlock;
    wire logic yel_steady = (state.auto_cfg & state.restart_cnt) | state.warn_int;
    sld_pkg::sld_led_t led_d;
    sld_pkg::sld_led_t led_q;

    always_comb begin
        led_d = '0;
        if (boot) begin
            led_d.off_red = 1'b1; // RULE_09
            led_d.on_green = 1'b0; // RULE_09
        end else begin
            led_d.on_green = state.out_on; // RULE_01 RULE_10
            if (state.off_fault) begin
                led_d.off_red = phase; // RULE_03
            end else begin
                led_d.off_red = state.off_field; // RULE_02
            end
            if (yel_blink) begin
                led_d.rw_yellow = phase; // RULE_04 RULE_15
            end else begin
                led_d.rw_yellow = yel_steady; // RULE_05 RULE_06
            end
            led_d.net_green = state.eth_link; // RULE_07
            led_d.net_yellow = state.eth_traffic & phase; // RULE_08
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            led_q <= '0;
        end else begin
            led_q <= led_d; // RULE_12
        end
    end
    assign led = led_q;

    // ==========================================================
    // Button edge detect
    logic btn_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            btn_q <= 1'b0;
        end else begin
            btn_q <= button;
        end
    end
    wire logic press = button & ~btn_q;

    // ==========================================================
    // Display state and blanking timer
    wire logic activity = state.off_field | state.warn_int | state.notify | state.off_fault
        | (state.reset_cfg & state.interlock) | (state.auto_cfg & state.restart_cnt);
    sld_pkg::sld_disp_t ds_q;
    sld_pkg::sld_disp_t ds_d;
    logic [TW-1:0] tmr_q;
    wire logic tmr_done = (tmr_q >= TW'(BLANK_CYC - 1));
    logic [PAGE_W-1:0] page_q;
    logic [PAGE_W-1:0] pages_q;

    always_comb begin
        case (ds_q)
            sld_pkg::SLD_DISP_BOOT: ds_d = boot ? sld_pkg::SLD_DISP_BOOT : sld_pkg::SLD_DISP_ON;
            sld_pkg::SLD_DISP_ON: begin
                if (boot) begin
                    ds_d = sld_pkg::SLD_DISP_BOOT;
                end else if (tmr_done && !activity && !press) begin
                    ds_d = sld_pkg::SLD_DISP_OFF; // RULE_11
                end else begin
                    ds_d = sld_pkg::SLD_DISP_ON;
                end
            end
            sld_pkg::SLD_DISP_OFF: begin
                if (boot) begin
                    ds_d = sld_pkg::SLD_DISP_BOOT;
                end else if (press || activity) begin
                    ds_d = sld_pkg::SLD_DISP_ON; // RULE_13
                end else begin
                    ds_d = sld_pkg::SLD_DISP_OFF;
                end
            end
            default: ds_d = sld_pkg::SLD_DISP_BOOT;
        endcase
    end

    wire logic page_step = (ds_q == sld_pkg::SLD_DISP_ON) && press && (pages_q > PAGE_W'(1));
    wire logic blank_ev = (ds_q == sld_pkg::SLD_DISP_ON) && (ds_d == sld_pkg::SLD_DISP_OFF);
    wire logic wake_ev = (ds_q == sld_pkg::SLD_DISP_OFF) && (ds_d == sld_pkg::SLD_DISP_ON);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ds_q <= sld_pkg::SLD_DISP_BOOT;
            tmr_q <= '0;
            page_q <= '0;
        end else begin
            ds_q <= ds_d;
            if (ds_q != sld_pkg::SLD_DISP_ON || activity || press) begin
                tmr_q <= '0; // RULE_11
            end else if (!tmr_done) begin
                tmr_q <= tmr_q + TW'(1);
            end
            if (ds_q != sld_pkg::SLD_DISP_ON) begin
                page_q <= '0;
            end else if (page_step) begin
                page_q <= (page_q >= pages_q - PAGE_W'(1)) ? '0 : page_q + PAGE_W'(1); // RULE_14
            end
        end
    end
    assign disp_on = (ds_q != sld_pkg::SLD_DISP_OFF); // RULE_10
    assign disp_page = page_q;

    // ==========================================================
    // Read handshake: one wait state so registered read data stands at the answer
    logic rvalid_q;
    wire logic rd_take = avs_read & ~rvalid_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_take;
        end
    end
    assign avs_waitrequest = rd_take;

    // ==========================================================
    // Register bus
    logic [sld_pkg::IRQ_W-1:0] ist_q;
    logic [sld_pkg::IRQ_W-1:0] imask_q;
    logic [31:0] rdata_q;
    wire logic fault_ev = state.off_fault & ~led_q.on_green & ~boot;
    logic fault_q;
    wire logic [sld_pkg::IRQ_W-1:0] ev = {fault_ev & ~fault_q, page_step, wake_ev, blank_ev};
    wire logic wr_ist = avs_write && avs_address == sld_pkg::OFS_INT_STAT && avs_byteenable[0];
    wire logic wr_imask = avs_write && avs_address == sld_pkg::OFS_INT_MASK && avs_byteenable[0];
    wire logic wr_ctrl = avs_write && avs_address == sld_pkg::OFS_CTRL && avs_byteenable[0];
    wire logic [sld_pkg::IRQ_W-1:0] clr = wr_ist ? avs_writedata[sld_pkg::IRQ_W-1:0] : '0;
    wire logic [sld_pkg::IRQ_W-1:0] ev_clr = ev & clr;
    wire logic [31:0] stat_word = {18'h0, ds_q, page_q, 3'h0, led_q};
    logic [31:0] rd_mux;

    always_comb begin
        case (avs_address)
            sld_pkg::OFS_STATUS: rd_mux = stat_word;
            sld_pkg::OFS_INT_STAT: rd_mux = {28'h0, ist_q};
            sld_pkg::OFS_INT_MASK: rd_mux = {28'h0, imask_q};
            sld_pkg::OFS_CTRL: rd_mux = {28'h0, pages_q};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ist_q <= '0;
            imask_q <= '0;
            pages_q <= PAGE_W'(sld_pkg::CTRL_RESET);
            rdata_q <= '0;
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_ev;
            ist_q <= (ist_q & ~clr) | ev;
            if (wr_imask) begin
                imask_q <= avs_writedata[sld_pkg::IRQ_W-1:0];
            end
            if (wr_ctrl) begin
                pages_q <= avs_writedata[sld_pkg::CTRL_PAGES_LSB +: PAGE_W];
            end
            if (rd_take) begin
                rdata_q <= rd_mux;
            end
        end
    end
    assign avs_readdata = rdata_q;
    assign irq = |(ist_q & imask_q);

    // ==========================================================
    // Lamp checks
    AST_ON_GREEN: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
        1 |=> led.on_green == ($past(state.out_on) && !$past(boot)))
        else $error("ON LED wrong");
    AST_OFF_FIELD: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
        (!boot && state.off_field && !state.off_fault) |=> led.off_red)
        else $error("OFF LED not steady on field");
    AST_OFF_FAULT: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
        (!boot && state.off_fault) |=> led.off_red == $past(phase))
        else $error("OFF LED not blinking on fault");
    AST_YEL_BLINK: assert property (@(posedge clk) disable iff (!rstn) // RULE_04 RULE_15
        (!boot && yel_blink) |=> led.rw_yellow == $past(phase))
        else $error("Yellow not blinking on interlock");
    AST_YEL_STEADY: assert property (@(posedge clk) disable iff (!rstn) // RULE_05 RULE_06
        (!boot && !yel_blink && yel_steady) |=> led.rw_yellow)
        else $error("Yellow not steady");
    AST_NET: assert property (@(posedge clk) disable iff (!rstn) // RULE_07 RULE_08
        !boot |=> led.net_green == $past(state.eth_link)
        && led.net_yellow == ($past(state.eth_traffic) && $past(phase)))
        else $error("Network LED wrong");
    AST_BOOT: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
        boot |=> led.off_red && !led.on_green)
        else $error("Start-up pattern wrong");

    // ==========================================================
    // Display checks
    AST_ACT_KEEP: assert property (@(posedge clk) disable iff (!rstn) // RULE_11 RULE_10
        (activity && !boot && disp_on) |=> disp_on)
        else $error("Display blanked during activity");
    AST_TMR_CLR: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
        (!boot && activity) |=> tmr_q == '0)
        else $error("Blank timer not restarted");
    AST_WAKE_ACT: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
        (!disp_on && activity && !boot) |=> disp_on)
        else $error("Display did not wake on activity");
    AST_BLANK_EV: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
        blank_ev |=> ist_q[sld_pkg::IRQ_BLANK])
        else $error("Blank event lost");
    AST_BOOT_DISP: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
        boot |=> ds_q == sld_pkg::SLD_DISP_BOOT)
        else $error("Display left start-up early");
    AST_WAKE: assert property (@(posedge clk) disable iff (!rstn) // RULE_13
        (!disp_on && press && !boot) |=> disp_on)
        else $error("Display did not wake");
    AST_PAGE: assert property (@(posedge clk) disable iff (!rstn) // RULE_14
        page_step |=> disp_page != $past(disp_page))
        else $error("Page did not advance");
    AST_PAGE_HOLD: assert property (@(posedge clk) disable iff (!rstn) // RULE_14
        (ds_q == sld_pkg::SLD_DISP_ON && press && pages_q <= PAGE_W'(1)) |=> $stable(disp_page))
        else $error("Page moved with a single page");
    AST_PAGE_HOME: assert property (@(posedge clk) disable iff (!rstn) // RULE_14
        (ds_q != sld_pkg::SLD_DISP_ON) |=> disp_page == '0)
        else $error("Page not reset while dark");

    // ==========================================================
    // Bus and interrupt checks
    AST_RD_ONE_WAIT: assert property (@(posedge clk) disable iff (!rstn)
        (avs_read && avs_waitrequest) |=> (!avs_read || !avs_waitrequest))
        else $error("Read answer late");
    AST_WR_NO_WAIT: assert property (@(posedge clk) disable iff (!rstn)
        (avs_write && !avs_read) |-> !avs_waitrequest)
        else $error("Write stalled");
    AST_SET_WINS: assert property (@(posedge clk) disable iff (!rstn)
        (|ev_clr) |=> ((ist_q & $past(ev_clr)) == $past(ev_clr)))
        else $error("Clear beat a new event");
    AST_W1C: assert property (@(posedge clk) disable iff (!rstn)
        (wr_ist && !(|ev)) |=> ((ist_q & $past(clr)) == '0))
        else $error("Status bit not cleared");
    AST_IRQ_EV: assert property (@(posedge clk) disable iff (!rstn)
        (|(ev & imask_q) && !wr_imask) |=> irq)
        else $error("Unmasked event gave no interrupt");
    AST_FAULT_EV: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
        (!boot && $rose(state.off_fault) && !led.on_green) |=> ist_q[sld_pkg::IRQ_FAULT])
        else $error("Fault event lost");
    COV_BLANK: cover property (@(posedge clk) disable iff (!rstn) blank_ev);
    COV_WAKE: cover property (@(posedge clk) disable iff (!rstn) wake_ev);
    COV_PAGE: cover property (@(posedge clk) disable iff (!rstn) page_step);
    COV_IRQ: cover property (@(posedge clk) disable iff (!rstn) irq);
    COV_RD: cover property (@(posedge clk) disable iff (!rstn) avs_read && !avs_waitrequest);
endmodule // sld_top

// ### verif/sld_panel.sv
// Behavioural model of the LED panel and pixel display fed by the driver.
// Assumes LED levels settled at each rising clock edge.
`timescale 1ns/10ps
module sld_panel (
    input wire logic clk,
    input wire logic clr,
    input sld_pkg::sld_led_t led,
    input wire logic disp_on,
    input wire logic [3:0] disp_page,
    output logic [4:0] seen_hi,
    output logic [4:0] seen_lo,
    output logic [3:0] shown_page
);
    // ==========================================================
    // Lamp history: a lamp seen both lit and dark is blinking
    always @(posedge clk) begin
        if (clr) begin
            seen_hi <= 5'h00;
            seen_lo <= 5'h00;
        end else begin
            seen_hi <= seen_hi | led;
            seen_lo <= seen_lo | ~led;
        end
    end

    // ==========================================================
    // A dark display shows no page
    assign shown_page = disp_on ? disp_page : 4'hf;
endmodule // sld_panel

// ### verif/tb_sld_top.sv
// Self-checking bench for the status LED and display driver.
// Assumes short blink and blanking counts set by parameter.
`timescale 1ns/10ps
module tb_sld_top;
    logic clk, rstn, button, clr, avs_read, avs_write, avs_waitrequest, irq, disp_on;
    sld_pkg::sld_state_t state;
    sld_pkg::sld_led_t led;
    logic [3:0] disp_page, avs_address, avs_byteenable, shown_page;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [4:0] seen_hi, seen_lo, eh, el, hi, lo;
    int fails, total_checks, n;
    logic [21:0] rows [10] = '{{12'h800, 5'h08, 5'h10}, {12'h400, 5'h10, 5'h0f},
        {12'h200, 5'h08, 5'h17}, {12'h100, 5'h08, 5'h1f}, {12'h0c0, 5'h04, 5'h1f},
        {12'h030, 5'h04, 5'h1b}, {12'h008, 5'h04, 5'h1b}, {12'h004, 5'h02, 5'h1d},
        {12'h006, 5'h03, 5'h1d}, {12'h0f8, 5'h04, 5'h1f}};

    sld_top #(.BLANK_CYC(50), .BLINK_CYC(4)) sld_top_i (.clk(clk), .rstn(rstn),
        .state(state), .button(button), .led(led), .disp_on(disp_on),
        .disp_page(disp_page), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));
    sld_panel sld_panel_i (.clk(clk), .clr(clr), .led(led), .disp_on(disp_on),
        .disp_page(disp_page), .seen_hi(seen_hi), .seen_lo(seen_lo),
        .shown_page(shown_page));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ==========================================================
    // Reporting
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    // ==========================================================
    // Avalon-MM master; data is taken at the edge where waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (avs_waitrequest !== 1'b0) begin
            cmp("waitrequest", 32'h0, 32'h1);
            complete_run;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic press;
        button <= 1'b1;
        repeat (2) @(posedge clk);
        button <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic wait_disp(input logic v, input int maxc);
        n = 0;
        while (disp_on !== v && n < maxc) begin
            @(posedge clk);
            n++;
        end
        if (disp_on !== v) begin
            cmp("disp_on wait", 32'(v), 32'(disp_on));
            complete_run;
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        cmp("watchdog", 32'h0, 32'h1);
        complete_run;
    end

    // ==========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        state = '0;
        button = 1'b0;
        clr = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        cmp("reset led", 32'h0, 32'(led));
        cmp("reset disp_on", 32'h1, 32'(disp_on));
        cmp("reset irq", 32'h0, 32'(irq));
        bus(1'b0, sld_pkg::OFS_CTRL, 32'h0);
        cmp("ctrl reset", sld_pkg::CTRL_RESET, rd);
        bus(1'b0, 4'h2, 32'h0);
        cmp("unmapped read", 32'h0, rd);
        for (int i = 0; i < 10; i++) begin
            state <= rows[i][21:10];
            repeat (3) @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            repeat (12) @(posedge clk);
            eh = rows[i][9:5];
            el = rows[i][4:0];
            hi = seen_hi & (eh | el);
            lo = seen_lo & (eh | el);
            cmp("on/off lit", 32'(eh[4:3]), 32'(hi[4:3]));
            cmp("on/off dark", 32'(el[4:3]), 32'(lo[4:3]));
            cmp("yellow lit", 32'(eh[2]), 32'(hi[2]));
            cmp("yellow dark", 32'(el[2]), 32'(lo[2]));
            cmp("net lit", 32'(eh[1:0]), 32'(hi[1:0]));
            cmp("net dark", 32'(el[1:0]), 32'(lo[1:0]));
        end
        state <= '0;
        @(posedge clk);
        wait_disp(1'b0, 80);
        cmp("blank delay", 32'h1, 32'(n >= 45 && n <= 56));
        cmp("panel dark", 32'hf, 32'(shown_page));
        bus(1'b0, sld_pkg::OFS_STATUS, 32'h0);
        cmp("status disp", 32'h2, 32'(rd[13:12]));
        bus(1'b0, sld_pkg::OFS_INT_STAT, 32'h0);
        cmp("blank event", 32'h1, 32'(rd[sld_pkg::IRQ_BLANK]));
        bus(1'b1, sld_pkg::OFS_INT_MASK, 32'h1);
        cmp("irq set", 32'h1, 32'(irq));
        bus(1'b1, sld_pkg::OFS_INT_STAT, 32'h1);
        cmp("irq clear", 32'h0, 32'(irq));
        press;
        cmp("wake", 32'h1, 32'(disp_on));
        cmp("wake page", 32'h0, 32'(disp_page));
        bus(1'b1, sld_pkg::OFS_CTRL, 32'h3);
        for (int p = 1; p <= 3; p++) begin
            press;
            cmp("page step", 32'(p % 3), 32'(disp_page));
        end
        bus(1'b0, sld_pkg::OFS_INT_STAT, 32'h0);
        cmp("events", 32'he, rd);
        repeat (30) @(posedge clk);
        state.notify <= 1'b1;
        @(posedge clk);
        state.notify <= 1'b0;
        repeat (35) @(posedge clk);
        cmp("timer restart", 32'h1, 32'(disp_on));
        complete_run;
    end
endmodule // tb_sld_top
